// ==== logic/pmsl_pkg.sv ====
// Package for the per-port multicast-event send and lookup parity capture.
// Assumes a 32-bit AHB-Lite slave and one switch clock.
// Bit positions below are little-endian (bit 0 = LSB) register positions.

`default_nettype none

package pmsl_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 17;
  localparam logic [16:0] OFF_PORT_CTL = 17'h13000;
  localparam logic [16:0] OFF_MCS_SEND = 17'h1300C;
  localparam logic [16:0] OFF_LUT_INFO = 17'h13010;
  localparam logic [16:0] OFF_IRQ_STATUS = 17'h13020;
  localparam logic [16:0] OFF_IRQ_CLEAR = 17'h13024;
  localparam logic [16:0] OFF_IRQ_ENABLE = 17'h13028;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int SEND_BIT = 0;
  localparam int DONE_BIT = 1;
  localparam int CTL_MULTICAST_SYMBOL_FORWARD_ENABLE_BIT = 0;
  localparam int CTL_PAR_IRQ_EN_BIT = 16;
  localparam int INFO_UPPER_LSB = 24;
  localparam int INFO_LOWER_LSB = 16;
  localparam int INFO_LARGE_BIT = 15;
  localparam int INFO_PARITY_BIT = 7;
  localparam int INFO_VALID_BIT = 6;
  localparam int INFO_PORT_LSB = 0;
  localparam int IRQ_W = 2;
  localparam int IRQ_PAR_BIT = 0;
  localparam int IRQ_SENT_BIT = 1;

  // ----------------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------------
  localparam logic [31:0] SEND_RESET = 32'h00000002;
  localparam logic [31:0] INFO_RESET = 32'h00000000;
  localparam logic [31:0] INFO_WR_MASK = 32'hFFFF80CF;
  localparam logic [31:0] CTL_WR_MASK = 32'h00010001;
  localparam logic [31:0] CTL_RESET = 32'h00000000;
  localparam logic [3:0] PORT_UNMAPPED = 4'hF;
  localparam logic [1:0] TT_SMALL = 2'h0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PMSL_IDLE = 2'b00,
    PMSL_EVAL = 2'b01,
    PMSL_QUEUE = 2'b10
  } pmsl_state_t;

  // Failing lookup details, strobe qualifies the rest
  typedef struct packed {
    logic strobe;
    logic [15:0] dest_id;
    logic [1:0] tt;
    logic parity;
    logic entry_valid;
    logic [3:0] port;
  } pmsl_lut_err_t;

  // Latched AHB address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [16:0] addr;
  } pmsl_aphase_t;

endpackage

`default_nettype wire

// ==== logic/pmsl_sticky.sv ====
// Sticky event flags: hardware sets, software clears, set wins.
// Assumes set and clr are synchronous one-cycle or level terms.

`timescale 1ns/1ps
`default_nettype none

module pmsl_sticky #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Set and clear terms
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  // Flag state
  output logic [W-1:0] q
);

  logic [W-1:0] q_q;
  logic [W-1:0] q_d;

  // Set overrides a clear arriving in the same cycle
  assign q_d = (q_q & ~clr) | set;
  assign q = q_q;

  // Flag storage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_q <= '0;
    end else begin
      q_q <= q_d;
    end
  end

endmodule

`default_nettype wire

// ==== logic/pmsl_top.sv ====
// Per-port multicast-event send and lookup parity capture registers.
// Assumes an AHB-Lite master, an outbound queue that acknowledges a request
// with mcs_queued and reports transmission with mcs_sent.
//
// Our own choice: register access over AHB-Lite.

`timescale 1ns/1ps
`default_nettype none

module pmsl_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Outbound symbol queue
  output logic mcs_req,
  input wire logic mcs_queued,
  input wire logic mcs_sent,
  // Lookup table error report
  input wire pmsl_pkg::pmsl_lut_err_t lut_err,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------------
  // Bus address phase
  // ----------------------------------------------------------------------
  pmsl_pkg::pmsl_aphase_t aph_q;
  pmsl_pkg::pmsl_aphase_t aph_d;
  pmsl_pkg::pmsl_state_t state_q;
  pmsl_pkg::pmsl_state_t state_d;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;
  logic mcs_req_q;
  logic done_q;
  logic irq_q;
  logic [31:0] ctl_q;
  logic [31:0] info_q;
  logic [31:0] info_d;
  logic [pmsl_pkg::IRQ_W-1:0] irq_en_q;
  logic [pmsl_pkg::IRQ_W-1:0] irq_status;
  logic [pmsl_pkg::IRQ_W-1:0] irq_set;
  logic [pmsl_pkg::IRQ_W-1:0] irq_clr;
  logic [31:0] rd_mux;

  wire accept = hsel & htrans[1] & hready;
  wire [16:0] a_off = haddr[16:0];
  wire a_send = a_off == pmsl_pkg::OFF_MCS_SEND;

  // Decode of the latched data phase
  wire dp_wr = aph_q.valid & aph_q.write;
  wire wr_ctl = dp_wr & (aph_q.addr == pmsl_pkg::OFF_PORT_CTL);
  wire wr_info = dp_wr & (aph_q.addr == pmsl_pkg::OFF_LUT_INFO);
  wire wr_clr = dp_wr & (aph_q.addr == pmsl_pkg::OFF_IRQ_CLEAR);
  wire wr_en = dp_wr & (aph_q.addr == pmsl_pkg::OFF_IRQ_ENABLE);

  // Control bits steering the block
  wire mcs_fwd_en = ctl_q[pmsl_pkg::CTL_MULTICAST_SYMBOL_FORWARD_ENABLE_BIT];
  wire par_irq_en = ctl_q[pmsl_pkg::CTL_PAR_IRQ_EN_BIT];
  wire frozen = irq_status[pmsl_pkg::IRQ_PAR_BIT];

  assign aph_d.valid = accept;
  assign aph_d.write = hwrite;
  assign aph_d.addr = a_off;

  // Address phase capture; only whole-word singles are expected
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_q <= '0;
    end else if (hreadyout_q) begin
      aph_q <= aph_d;
    end
  end

  // ----------------------------------------------------------------------
  // Multicast-event send sequencing
  // ----------------------------------------------------------------------
  // Trigger: send bit written while idle-ready and forwarding enabled
  wire send_one = hwdata[pmsl_pkg::SEND_BIT];
  wire trigger = (state_q == pmsl_pkg::PMSL_EVAL) & send_one & done_q &
                 mcs_fwd_en;

  // Send-register writes stall the bus from data phase onward
  always_comb begin
    state_d = state_q;
    case (state_q)
      pmsl_pkg::PMSL_IDLE: begin
        if (accept & hwrite & a_send) begin
          state_d = pmsl_pkg::PMSL_EVAL;
        end
      end
      pmsl_pkg::PMSL_EVAL: begin
        if (trigger) begin
          state_d = pmsl_pkg::PMSL_QUEUE;
        end else begin
          state_d = pmsl_pkg::PMSL_IDLE;
        end
      end
      pmsl_pkg::PMSL_QUEUE: begin
        if (mcs_queued) begin
          state_d = pmsl_pkg::PMSL_IDLE;
        end
      end
      default: begin
        state_d = pmsl_pkg::PMSL_IDLE;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= pmsl_pkg::PMSL_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Queue request held until the queue takes it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mcs_req_q <= 1'b0;
    end else if (trigger) begin
      mcs_req_q <= 1'b1;
    end else if (mcs_queued) begin
      mcs_req_q <= 1'b0;
    end
  end

  // Done flag: cleared on trigger, set once the symbol has gone out
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q <= pmsl_pkg::SEND_RESET[pmsl_pkg::DONE_BIT];
    end else if (trigger) begin
      done_q <= 1'b0;
    end else if (mcs_sent & ~mcs_req_q) begin
      done_q <= 1'b1;
    end
  end

  // Bus ready: low through a send write until it is queued or refused
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
    end else if (state_d != pmsl_pkg::PMSL_IDLE) begin
      hreadyout_q <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Lookup parity error capture
  // ----------------------------------------------------------------------
  // Capture when free, or when software releases it in the same cycle
  wire par_release = wr_clr & hwdata[pmsl_pkg::IRQ_PAR_BIT];
  wire capture = lut_err.strobe & (~frozen | par_release);
  wire large_id = lut_err.tt != pmsl_pkg::TT_SMALL;
  wire [7:0] id_upper = large_id ? lut_err.dest_id[15:8] :
                        lut_err.dest_id[7:0];
  wire [7:0] id_lower = large_id ? lut_err.dest_id[7:0] : 8'h00;
  wire [3:0] cap_port = lut_err.entry_valid ? lut_err.port :
                        pmsl_pkg::PORT_UNMAPPED;
  wire info_sw_ok = wr_info & frozen & ~capture;

  // Next value of the info register
  always_comb begin
    info_d = info_q;
    if (capture) begin
      info_d = '0;
      info_d[pmsl_pkg::INFO_UPPER_LSB +: 8] = id_upper;
      info_d[pmsl_pkg::INFO_LOWER_LSB +: 8] = id_lower;
      info_d[pmsl_pkg::INFO_LARGE_BIT] = large_id;
      info_d[pmsl_pkg::INFO_PARITY_BIT] = lut_err.parity;
      info_d[pmsl_pkg::INFO_VALID_BIT] = lut_err.entry_valid;
      info_d[pmsl_pkg::INFO_PORT_LSB +: 4] = cap_port;
    end else if (info_sw_ok) begin
      info_d = hwdata & pmsl_pkg::INFO_WR_MASK;
    end
  end

  // Info register storage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      info_q <= pmsl_pkg::INFO_RESET;
    end else begin
      info_q <= info_d;
    end
  end

  // ----------------------------------------------------------------------
  // Control, interrupt enable and status
  // ----------------------------------------------------------------------
  // Port control and interrupt enable registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_q <= pmsl_pkg::CTL_RESET;
      irq_en_q <= '0;
    end else begin
      if (wr_ctl) begin
        ctl_q <= hwdata & pmsl_pkg::CTL_WR_MASK;
      end
      if (wr_en) begin
        irq_en_q <= hwdata[pmsl_pkg::IRQ_W-1:0];
      end
    end
  end

  // Event sources and software clears
  assign irq_set[pmsl_pkg::IRQ_PAR_BIT] = lut_err.strobe;
  assign irq_set[pmsl_pkg::IRQ_SENT_BIT] = mcs_sent & ~mcs_req_q;
  assign irq_clr = wr_clr ? hwdata[pmsl_pkg::IRQ_W-1:0] : '0;

  pmsl_sticky #(
    .W(pmsl_pkg::IRQ_W)
  ) u_status (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(irq_set),
    .clr(irq_clr),
    .q(irq_status)
  );

  // Parity events also need the port-control enable
  wire par_irq = irq_status[pmsl_pkg::IRQ_PAR_BIT] &
                 irq_en_q[pmsl_pkg::IRQ_PAR_BIT] & par_irq_en;
  wire sent_irq = irq_status[pmsl_pkg::IRQ_SENT_BIT] &
                  irq_en_q[pmsl_pkg::IRQ_SENT_BIT];

  // Interrupt output register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= par_irq | sent_irq;
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  wire [31:0] send_view = {30'h00000000, done_q, 1'b0};
  wire [31:0] st_view = {30'h00000000, irq_status};
  wire [31:0] en_view = {30'h00000000, irq_en_q};

  // Read selection; unmapped and write-only addresses read zero
  assign rd_mux = (a_off == pmsl_pkg::OFF_PORT_CTL) ? ctl_q :
                  (a_off == pmsl_pkg::OFF_MCS_SEND) ? send_view :
                  (a_off == pmsl_pkg::OFF_LUT_INFO) ? info_q :
                  (a_off == pmsl_pkg::OFF_IRQ_STATUS) ? st_view :
                  (a_off == pmsl_pkg::OFF_IRQ_ENABLE) ? en_view :
                  32'h00000000;

  // Read data registered at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
      hresp_q <= 1'b0;
    end else if (accept & ~hwrite & hreadyout_q) begin
      hrdata_q <= rd_mux;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign mcs_req = mcs_req_q;
  assign irq = irq_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  chk_send_emits: assert property (
    trigger |=> mcs_req_q [*1] ##0 !done_q)
    else $error("send write did not raise a queue request");

  chk_fwd_gate: assert property (
    $rose(mcs_req_q) |-> $past(mcs_fwd_en))
    else $error("symbol requested while forwarding disabled");

  chk_write_stall: assert property (
    mcs_req_q |-> !hreadyout_q)
    else $error("send write completed before symbol queued");

  chk_single_pending: assert property (
    $rose(mcs_req_q) |-> $past(done_q, 1))
    else $error("second request accepted while one pending");

  chk_done_clears: assert property (
    (state_q == pmsl_pkg::PMSL_EVAL && send_one && done_q && mcs_fwd_en)
      |=> !done_q ##1 !done_q)
    else $error("done flag not cleared by send");

  chk_done_sets: assert property (
    (!done_q && !mcs_req_q && mcs_sent && !trigger) |=> done_q)
    else $error("done flag not set after transmission");

  chk_info_frozen: assert property (
    (frozen && !par_release && !info_sw_ok) |=> $stable(info_q))
    else $error("info register changed while frozen");

  chk_info_wr_block: assert property (
    (!frozen && !lut_err.strobe) |=> $stable(info_q))
    else $error("info register written while no error flagged");

  chk_capture_ids: assert property (
    (capture && large_id) |=>
      info_q[31:16] == $past(lut_err.dest_id) &&
      info_q[pmsl_pkg::INFO_LARGE_BIT])
    else $error("large destination ID captured wrongly");

  chk_small_id: assert property (
    (capture && !large_id) |=>
      info_q[31:16] == {$past(lut_err.dest_id[7:0]), 8'h00})
    else $error("small destination ID captured wrongly");

  chk_unmapped_port: assert property (
    (capture && !lut_err.entry_valid) |=>
      info_q[3:0] == 4'hF && !info_q[pmsl_pkg::INFO_VALID_BIT])
    else $error("unmapped entry did not give port 0xF");

  chk_parity_irq: assert property (
    (par_irq_en == 1'b0 && !sent_irq) |=> !irq_q)
    else $error("parity interrupt raised while disabled");

  chk_release: assert property (
    (par_release && !lut_err.strobe) |=> !frozen ##1
      (!lut_err.strobe || capture))
    else $error("parity error indication not released");

endmodule

`default_nettype wire

// ==== bench/pmsl_queue_model.sv ====
// Outbound symbol queue and link partner model for the send request.
// Assumes mcs_req is a level that is held until mcs_queued is taken.

`timescale 1ns/1ps
`default_nettype none

module pmsl_queue_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Request and answer delays in cycles
  input wire logic mcs_req,
  input wire logic [3:0] q_dly,
  input wire logic [3:0] s_dly,
  // Answers and symbol count
  output logic mcs_queued,
  output logic mcs_sent,
  output logic [7:0] sym_cnt
);
  // ----------------------------------------------------------------------
  // Queue one request, then transmit it after a delay
  // ----------------------------------------------------------------------
  initial begin
    mcs_queued = 1'b0;
    mcs_sent = 1'b0;
    sym_cnt = 8'h00;
    forever begin
      @(posedge hclk);
      if (hresetn && mcs_req) begin
        repeat (q_dly) @(posedge hclk);
        mcs_queued <= 1'b1;
        sym_cnt <= sym_cnt + 8'h01;
        @(posedge hclk);
        mcs_queued <= 1'b0;
        repeat (s_dly) @(posedge hclk);
        mcs_sent <= 1'b1;
        @(posedge hclk);
        mcs_sent <= 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the send and lookup parity capture registers.
// Assumes one AHB-Lite master and the queue model on the symbol side.

`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic hclk, hresetn, hsel, hwrite, mcs_req, mcs_queued, mcs_sent, irq;
  logic hreadyout, hresp, rd_dp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] q_dly, s_dly;
  logic [7:0] sym_cnt;
  pmsl_pkg::pmsl_lut_err_t lut_err, e, x;
  logic [31:0] exp_q[$];
  int err_count, n_tests, i;

  // ----------------------------------------------------------------------
  // Design, partner and clock
  // ----------------------------------------------------------------------
  pmsl_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mcs_req(mcs_req),
    .mcs_queued(mcs_queued), .mcs_sent(mcs_sent), .lut_err(lut_err),
    .irq(irq));
  pmsl_queue_model partner (.hclk(hclk), .hresetn(hresetn),
    .mcs_req(mcs_req), .q_dly(q_dly), .s_dly(s_dly),
    .mcs_queued(mcs_queued), .mcs_sent(mcs_sent), .sym_cnt(sym_cnt));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // ----------------------------------------------------------------------
  // Compare, verdict and bus tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] ev,
                     input logic [31:0] gv);
    n_tests++;
    if (gv !== ev) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, ev, gv);
    end
  endtask

  task automatic wrap_up();
    if (err_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Returns just after the rising edge that samples hready high
  task automatic wait_rdy();
    logic r;
    r = 1'b0;
    while (r !== 1'b1) begin
      @(negedge hclk);
      r = hreadyout;
      @(posedge hclk);
    end
  endtask

  task automatic xfer(input logic [16:0] a, input logic w,
                      input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {15'h0000, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
  endtask

  task automatic wr(input logic [16:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rd(input logic [16:0] a, input logic [31:0] ev);
    exp_q.push_back(ev);
    xfer(a, 1'b0, 32'h00000000);
  endtask

  // Looks at level outputs one edge after the last write has landed
  task automatic peek(input logic ei, input logic [7:0] es);
    @(posedge hclk);
    @(negedge hclk);
    chk("irq", {31'h00000000, ei}, {31'h00000000, irq});
    chk("symbols", {24'h000000, es}, {24'h000000, sym_cnt});
    @(posedge hclk);
  endtask

  task automatic inj(input pmsl_pkg::pmsl_lut_err_t v);
    v.strobe = 1'b1;
    lut_err <= v;
    @(posedge hclk);
    lut_err <= '0;
  endtask

  task automatic wait_sent();
    for (int k = 0; k < 100 && mcs_sent !== 1'b1; k++) @(posedge hclk);
    if (mcs_sent !== 1'b1) begin
      err_count++;
    end
    @(posedge hclk);
  endtask

  function automatic logic [31:0] info_exp(pmsl_pkg::pmsl_lut_err_t v);
    logic [31:0] r;
    logic lg;
    lg = (v.tt != pmsl_pkg::TT_SMALL);
    r = pmsl_pkg::INFO_RESET;
    r[pmsl_pkg::INFO_UPPER_LSB +: 8] = lg ? v.dest_id[15:8] : v.dest_id[7:0];
    r[pmsl_pkg::INFO_LOWER_LSB +: 8] = lg ? v.dest_id[7:0] : 8'h00;
    r[pmsl_pkg::INFO_LARGE_BIT] = lg;
    r[pmsl_pkg::INFO_PARITY_BIT] = v.parity;
    r[pmsl_pkg::INFO_VALID_BIT] = v.entry_valid;
    r[pmsl_pkg::INFO_PORT_LSB +: 4] = v.entry_valid ? v.port :
                                      pmsl_pkg::PORT_UNMAPPED;
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Read data monitor: oldest note against each completed read
  // ----------------------------------------------------------------------
  always @(posedge hclk) begin
    if (!hresetn) begin
      rd_dp <= 1'b0;
    end else if (hreadyout) begin
      if (rd_dp && exp_q.size() > 0) begin
        chk("hrdata", exp_q.pop_front(), hrdata);
      end
      rd_dp <= hsel && htrans[1] && !hwrite;
    end
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    wrap_up();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    lut_err = '0;
    q_dly = 4'h0;
    s_dly = 4'h0;
    err_count = 0;
    n_tests = 0;
    void'($urandom(32'hC4C9AB32));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values and an unmapped place
    rd(pmsl_pkg::OFF_MCS_SEND, pmsl_pkg::SEND_RESET);
    rd(pmsl_pkg::OFF_LUT_INFO, pmsl_pkg::INFO_RESET);
    rd(pmsl_pkg::OFF_PORT_CTL, pmsl_pkg::CTL_RESET);
    wr(17'h13030, 32'hFFFFFFFF);
    rd(17'h13030, 32'h00000000);
    // Send with forwarding off is dropped
    wr(pmsl_pkg::OFF_MCS_SEND, 32'h00000001);
    peek(1'b0, 8'h00);
    rd(pmsl_pkg::OFF_MCS_SEND, pmsl_pkg::SEND_RESET);
    wr(pmsl_pkg::OFF_PORT_CTL, 32'hFFFFFFFF);
    rd(pmsl_pkg::OFF_PORT_CTL, pmsl_pkg::CTL_WR_MASK);
    wr(pmsl_pkg::OFF_IRQ_ENABLE, 32'h00000002);
    // Sends with random queue and link delays
    for (i = 0; i < 4; i++) begin
      q_dly <= 4'($urandom_range(0, 6));
      s_dly <= 4'($urandom_range(10, 15));
      wr(pmsl_pkg::OFF_MCS_SEND, 32'h00000001);
      peek(1'b0, 8'(i + 1));
      rd(pmsl_pkg::OFF_MCS_SEND, 32'h00000000);
      wr(pmsl_pkg::OFF_MCS_SEND, 32'h00000001);
      wait_sent();
      rd(pmsl_pkg::OFF_MCS_SEND, pmsl_pkg::SEND_RESET);
      peek(1'b1, 8'(i + 1));
      wr(pmsl_pkg::OFF_IRQ_CLEAR, 32'h00000002);
      peek(1'b0, 8'(i + 1));
    end
    // Lookup parity capture over every type and valid combination
    wr(pmsl_pkg::OFF_IRQ_ENABLE, 32'h00000001);
    for (i = 0; i < 8; i++) begin
      e = pmsl_pkg::pmsl_lut_err_t'(25'($urandom));
      e.tt = i[1:0];
      e.entry_valid = i[2];
      wr(pmsl_pkg::OFF_PORT_CTL, {15'h0000, i[0], 15'h0000, 1'b1});
      inj(e);
      x = e;
      x.dest_id = ~e.dest_id;
      x.parity = ~e.parity;
      inj(x);
      rd(pmsl_pkg::OFF_LUT_INFO, info_exp(e));
      peek(i[0], 8'h04);
      rd(pmsl_pkg::OFF_IRQ_STATUS, 32'h00000001);
      wr(pmsl_pkg::OFF_LUT_INFO, ~info_exp(e));
      rd(pmsl_pkg::OFF_LUT_INFO, ~info_exp(e) & pmsl_pkg::INFO_WR_MASK);
      wr(pmsl_pkg::OFF_IRQ_CLEAR, 32'h00000001);
      peek(1'b0, 8'h04);
      wr(pmsl_pkg::OFF_LUT_INFO, 32'hFFFFFFFF);
      rd(pmsl_pkg::OFF_LUT_INFO, ~info_exp(e) & pmsl_pkg::INFO_WR_MASK);
    end
    repeat (2) @(posedge hclk);
    wrap_up();
  end
endmodule

`default_nettype wire
